// file: hw/tec_cfg.svh
// register addresses, field positions, codes and reset values of the timer control slice
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH

// ****************************************************************
// register addresses
// ****************************************************************
`define TEC_ADDR_PRESCALER 16'hFFBB
`define TEC_ADDR_CAPCMP    16'hFFBC
`define TEC_ADDR_OUTCTRL   16'hFFBD
`define TEC_REG_RESET      8'h00
`define TEC_RD_UNMAPPED    8'h00

// ****************************************************************
// timer_output_control fields
// ****************************************************************
`define TEC_OC_ONESHOT_EN  6
`define TEC_OC_INV_B       5
`define TEC_OC_ONESHOT_TRG 4
`define TEC_OC_LVL_SET     3
`define TEC_OC_LVL_CLR     2
`define TEC_OC_INV_A       1
`define TEC_OC_OUT_EN      0
`define TEC_OC_RSVD        7
`define TEC_LVL_LOW        2'h1
`define TEC_LVL_HIGH       2'h2

// ****************************************************************
// capture_compare_control fields
// ****************************************************************
`define TEC_CC_CMP0_CAP    0
`define TEC_CC_CAP0_TRG    1
`define TEC_CC_CMP1_CAP    2
`define TEC_CC_W           3

// ****************************************************************
// prescaler_edge_select fields and codes
// ****************************************************************
`define TEC_PS_EDGE_B_HI   7
`define TEC_PS_EDGE_B_LO   6
`define TEC_PS_EDGE_A_HI   5
`define TEC_PS_EDGE_A_LO   4
`define TEC_PS_CLK_HI      1
`define TEC_PS_CLK_LO      0
`define TEC_EDGE_FALL      2'h0
`define TEC_EDGE_RISE      2'h1
`define TEC_EDGE_BOTH      2'h3
`define TEC_CLK_FULL       2'h0
`define TEC_CLK_DIV4       2'h1
`define TEC_CLK_DIV256     2'h2
`define TEC_CLK_EDGE_A     2'h3
`define TEC_DIV4_LAST      2'h3
`define TEC_DIV256_LAST    8'hFF

// ****************************************************************
// run-mode codes
// ****************************************************************
`define TEC_RUN_STOP       2'h0
`define TEC_RUN_FREE       2'h1
`define TEC_RUN_CLR_EDGE   2'h2
`define TEC_RUN_CLR_MATCH  2'h3

`endif

// file: hw/tec_pkg.sv
// types shared by the timer control slice
package tec_pkg;

  // one-shot pulse sequencer states
  typedef enum logic [2:0] {
    TEC_OS_IDLE = 3'h1,
    TEC_OS_WAIT = 3'h2,
    TEC_OS_HIGH = 3'h4
  } tec_os_e;

endpackage

// file: hw/tec_edge_det.sv
// pin synchroniser and rise/fall detector for one timer input pin
module tec_edge_det (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  input  wire logic enable,
  input  wire logic armed,
  output logic      rise_q,
  output logic      fall_q
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;

  // two-flop synchroniser; only sync2_q is read by logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
    end
  end

  // before the first start the history reads low, so a high pin looks like a rise;
  // after a stop the history keeps tracking the pin and restart sees no false edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else if (enable || armed) begin
      prev_q <= sync2_q;
    end else begin
      prev_q <= 1'b0;
    end
  end

  // single-cycle strobes, only while the timer runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= enable && sync2_q && !prev_q;
      fall_q <= enable && !sync2_q && prev_q;
    end
  end

endmodule

// file: hw/tec_ctrl.sv
// timer output, capture/compare select and prescaler/edge-select control slice
//
// Contract
// - cmp0_capture_sel 0 compare, 1 capture
// - reverse-phase capture with both edges detects nothing
// - uncaptured timer_in_b edge raises irq_match_a
// - reset clears output control and prescaler to zero
// - oneshot_trigger write clears counter, reads zero
// - oneshot_enable picks one-shot, not in match-clear
// - invert on second-register match; irq_match_b unless cmp1_capture_sel is set
// - invert on first-register match; irq_match_a unless cmp0_capture_sel is set
// - level set/clear are write-only triggers
// - out_enable 0 holds timer_out low
// - per-pin edge field: fall, rise, both
// - first enable sees high pin as rising
// - run mode 00 stops clock and count
`include "tec_cfg.svh"

module tec_ctrl #(
  parameter int PRE_W = 8
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic [1:0]  run_mode,
  input  wire logic        match_a,
  input  wire logic        match_b,
  input  wire logic        timer_in_a,
  input  wire logic        timer_in_b,
  output logic             timer_out,
  output logic             irq_match_a,
  output logic             irq_match_b,
  output logic             count_tick,
  output logic             counter_clear,
  output logic             capture_a,
  output logic             capture_b,
  output logic             cmp0_capture_sel,
  output logic             cmp1_capture_sel
);

  // ****************************************************************
  // registers and decode
  // ****************************************************************
  logic [7:0]           prescaler_edge_select_q;
  logic [7:0]           timer_output_control_q;
  logic [`TEC_CC_W-1:0] capture_compare_control_q;
  logic                 started_q;
  logic [PRE_W-1:0]     pre_q;
  tec_pkg::tec_os_e     os_q;
  logic                 wr_ps;
  logic                 wr_cc;
  logic                 wr_oc;
  logic                 running;
  logic [1:0]           in_pins;
  logic [1:0]           rise;
  logic [1:0]           fall;
  logic [1:0]           sel_a;
  logic [1:0]           sel_b;
  logic [1:0]           clk_sel;
  logic [1:0]           lvl_cmd;
  logic                 valid_a;
  logic                 valid_b;
  logic                 rev_a;
  logic                 cap_a_d;
  logic                 cap_b_d;
  logic                 b_uncaptured;
  logic                 os_en;
  logic                 os_go;
  logic                 tick_d;

  assign wr_ps   = reg_wr && (reg_addr == `TEC_ADDR_PRESCALER);
  assign wr_cc   = reg_wr && (reg_addr == `TEC_ADDR_CAPCMP);
  assign wr_oc   = reg_wr && (reg_addr == `TEC_ADDR_OUTCTRL);
  assign running = (run_mode != `TEC_RUN_STOP);
  assign sel_a   = prescaler_edge_select_q[`TEC_PS_EDGE_A_HI:`TEC_PS_EDGE_A_LO];
  assign sel_b   = prescaler_edge_select_q[`TEC_PS_EDGE_B_HI:`TEC_PS_EDGE_B_LO];
  assign clk_sel = prescaler_edge_select_q[`TEC_PS_CLK_HI:`TEC_PS_CLK_LO];
  assign lvl_cmd = reg_wdata[`TEC_OC_LVL_SET:`TEC_OC_LVL_CLR];
  assign os_en   = timer_output_control_q[`TEC_OC_ONESHOT_EN];

  // register writes; software is trusted to respect the running-time write limits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescaler_edge_select_q   <= `TEC_REG_RESET;
      timer_output_control_q    <= `TEC_REG_RESET;
      capture_compare_control_q <= '0;
    end else begin
      if (wr_ps) begin
        prescaler_edge_select_q <= reg_wdata;
      end
      if (wr_cc) begin
        capture_compare_control_q <= reg_wdata[`TEC_CC_W-1:0];
      end
      // trigger bits are never stored, so they always read zero
      if (wr_oc) begin
        timer_output_control_q                        <= reg_wdata;
        timer_output_control_q[`TEC_OC_ONESHOT_TRG]   <= 1'b0;
        timer_output_control_q[`TEC_OC_LVL_SET]       <= 1'b0;
        timer_output_control_q[`TEC_OC_LVL_CLR]       <= 1'b0;
        timer_output_control_q[`TEC_OC_RSVD]          <= 1'b0;
      end
    end
  end

  // read data: unmapped addresses return zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `TEC_RD_UNMAPPED;
    end else if (reg_rd) begin
      case (reg_addr)
        `TEC_ADDR_PRESCALER: reg_rdata <= prescaler_edge_select_q;
        `TEC_ADDR_CAPCMP:    reg_rdata <= {5'h00, capture_compare_control_q};
        `TEC_ADDR_OUTCTRL:   reg_rdata <= timer_output_control_q;
        default:             reg_rdata <= `TEC_RD_UNMAPPED;
      endcase
    end
  end

  // ****************************************************************
  // input pins
  // ****************************************************************
  // remembers that the timer has run once, for the first-start rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      started_q <= 1'b0;
    end else if (running) begin
      started_q <= 1'b1;
    end
  end

  assign in_pins = {timer_in_b, timer_in_a};

  // one detector per pin
  for (genvar gi = 0; gi < 2; gi++) begin : g_pin
    tec_edge_det u_edge (
      .clk    (clk),
      .rst_n  (rst_n),
      .pin    (in_pins[gi]),
      .enable (running),
      .armed  (started_q),
      .rise_q (rise[gi]),
      .fall_q (fall[gi])
    );
  end

  // valid-edge selection; code 10 matches nothing
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    case (sel)
      `TEC_EDGE_FALL: edge_hit = f;
      `TEC_EDGE_RISE: edge_hit = r;
      `TEC_EDGE_BOTH: edge_hit = r | f;
      default:        edge_hit = 1'b0;
    endcase
  endfunction

  assign valid_a = edge_hit(sel_a, rise[0], fall[0]);
  assign valid_b = edge_hit(sel_b, rise[1], fall[1]);
  // reverse phase has no opposite of both edges, so that setting never fires
  assign rev_a   = (sel_a == `TEC_EDGE_FALL) ? rise[0] :
                   (sel_a == `TEC_EDGE_RISE) ? fall[0] : 1'b0;

  // ****************************************************************
  // capture and interrupt strobes
  // ****************************************************************
  assign cap_a_d = running && capture_compare_control_q[`TEC_CC_CMP0_CAP] &&
                   (capture_compare_control_q[`TEC_CC_CAP0_TRG] ? rev_a : valid_b);
  assign cap_b_d = running && capture_compare_control_q[`TEC_CC_CMP1_CAP] && valid_a;
  // a timer_in_b edge that feeds no capture still interrupts
  assign b_uncaptured = valid_b && !(capture_compare_control_q[`TEC_CC_CMP0_CAP] &&
                        !capture_compare_control_q[`TEC_CC_CAP0_TRG]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_a   <= 1'b0;
      capture_b   <= 1'b0;
      irq_match_a <= 1'b0;
      irq_match_b <= 1'b0;
    end else begin
      capture_a   <= cap_a_d;
      capture_b   <= cap_b_d;
      irq_match_a <= (match_a && !capture_compare_control_q[`TEC_CC_CMP0_CAP]) ||
                     cap_a_d || b_uncaptured;
      irq_match_b <= (match_b && !capture_compare_control_q[`TEC_CC_CMP1_CAP]) ||
                     cap_b_d;
    end
  end

  // mode selects handed to the capture/compare registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp0_capture_sel <= 1'b0;
      cmp1_capture_sel <= 1'b0;
    end else begin
      cmp0_capture_sel <= capture_compare_control_q[`TEC_CC_CMP0_CAP];
      cmp1_capture_sel <= capture_compare_control_q[`TEC_CC_CMP1_CAP];
    end
  end

  // ****************************************************************
  // count clock
  // ****************************************************************
  // prescaler restarts from zero on every start so the first tick is repeatable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
    end else if (running) begin
      pre_q <= pre_q + 1'b1;
    end else begin
      pre_q <= '0;
    end
  end

  always_comb begin
    case (clk_sel)
      `TEC_CLK_FULL:   tick_d = 1'b1;
      `TEC_CLK_DIV4:   tick_d = (pre_q[1:0] == `TEC_DIV4_LAST);
      `TEC_CLK_DIV256: tick_d = (pre_q[7:0] == `TEC_DIV256_LAST);
      default:         tick_d = valid_a;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_tick <= 1'b0;
    end else begin
      count_tick <= running && tick_d;
    end
  end

  // ****************************************************************
  // one-shot pulse and timer output
  // ****************************************************************
  // match-clear mode cannot run a one-shot; there the trigger only clears the counter
  assign os_go = os_en && running && (run_mode != `TEC_RUN_CLR_MATCH) &&
                 ((wr_oc && reg_wdata[`TEC_OC_ONESHOT_TRG]) ||
                  (run_mode == `TEC_RUN_CLR_EDGE && valid_a));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_clear <= 1'b0;
    end else begin
      counter_clear <= wr_oc && reg_wdata[`TEC_OC_ONESHOT_TRG];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      os_q <= tec_pkg::TEC_OS_IDLE;
    end else if (!running || !os_en) begin
      os_q <= tec_pkg::TEC_OS_IDLE;
    end else begin
      case (os_q)
        tec_pkg::TEC_OS_IDLE: if (os_go) os_q <= tec_pkg::TEC_OS_WAIT;
        tec_pkg::TEC_OS_WAIT: if (match_b) os_q <= tec_pkg::TEC_OS_HIGH;
        tec_pkg::TEC_OS_HIGH: if (match_a) os_q <= tec_pkg::TEC_OS_IDLE;
        default:              os_q <= tec_pkg::TEC_OS_IDLE;
      endcase
    end
  end

  // output level: disable wins, then level triggers, then one-shot or toggles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_out <= 1'b0;
    end else if (!timer_output_control_q[`TEC_OC_OUT_EN]) begin
      timer_out <= 1'b0;
    end else if (wr_oc && lvl_cmd == `TEC_LVL_LOW) begin
      timer_out <= 1'b0;
    end else if (wr_oc && lvl_cmd == `TEC_LVL_HIGH) begin
      timer_out <= 1'b1;
    end else if (os_en) begin
      if (os_q == tec_pkg::TEC_OS_WAIT && match_b) begin
        timer_out <= 1'b1;
      end else if (os_q == tec_pkg::TEC_OS_HIGH && match_a) begin
        timer_out <= 1'b0;
      end
    end else begin
      timer_out <= timer_out ^
        (match_a && timer_output_control_q[`TEC_OC_INV_A]) ^
        (match_b && timer_output_control_q[`TEC_OC_INV_B]);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_reset_clear: assert property ($rose(rst_n) |->
    prescaler_edge_select_q == `TEC_REG_RESET && timer_output_control_q == `TEC_REG_RESET)
    else $error("control registers not cleared by reset");
  a_oe_low: assert property (!timer_output_control_q[`TEC_OC_OUT_EN] |=> !timer_out)
    else $error("timer_out high while output disabled");
  a_trig_read: assert property (reg_rd && reg_addr == `TEC_ADDR_OUTCTRL |=>
    !reg_rdata[`TEC_OC_ONESHOT_TRG] && !reg_rdata[`TEC_OC_LVL_SET])
    else $error("trigger bit read back as one");
  a_trig_clear: assert property (wr_oc && reg_wdata[`TEC_OC_ONESHOT_TRG] |=>
    counter_clear ##1 !counter_clear)
    else $error("oneshot trigger did not clear counter for one cycle");
  a_level_high: assert property (wr_oc && lvl_cmd == `TEC_LVL_HIGH &&
    timer_output_control_q[`TEC_OC_OUT_EN] |=> timer_out)
    else $error("level set did not drive output high");
  a_irq_b: assert property (match_b && !capture_compare_control_q[`TEC_CC_CMP1_CAP]
    |=> irq_match_b)
    else $error("second-register match gave no interrupt");
  a_irq_a: assert property (match_a && !capture_compare_control_q[`TEC_CC_CMP0_CAP]
    |=> irq_match_a)
    else $error("first-register match gave no interrupt");
  a_toggle_b: assert property (match_b && !match_a && !wr_oc && !os_en &&
    timer_output_control_q[`TEC_OC_INV_B] && timer_output_control_q[`TEC_OC_OUT_EN]
    |=> timer_out != $past(timer_out))
    else $error("timer_out did not invert on second-register match");
  a_ext_irq: assert property (b_uncaptured |=> irq_match_a && !capture_a)
    else $error("uncaptured edge did not interrupt");
  a_rev_both: assert property (capture_compare_control_q[`TEC_CC_CAP0_TRG] &&
    sel_a == `TEC_EDGE_BOTH |=> !capture_a)
    else $error("reverse-phase capture fired on both-edge setting");
  a_cap_sel: assert property (running && valid_b &&
    capture_compare_control_q[`TEC_CC_CMP0_CAP] &&
    !capture_compare_control_q[`TEC_CC_CAP0_TRG] |=> capture_a)
    else $error("capture select did not capture");
  a_stop_tick: assert property (!running |=> !count_tick && !capture_a && !capture_b)
    else $error("count tick while stopped");
  a_full_tick: assert property (running && clk_sel == `TEC_CLK_FULL |=> count_tick)
    else $error("full-rate clock did not tick");
  a_strobe_one: assert property (rise[0] |=> !rise[0])
    else $error("edge strobe longer than one cycle");

  c_oneshot: cover property (os_q == tec_pkg::TEC_OS_WAIT ##[1:300]
    os_q == tec_pkg::TEC_OS_HIGH);
  c_capture_a: cover property (capture_a);
  c_ext_irq: cover property (b_uncaptured);
  c_level_set: cover property (wr_oc && lvl_cmd == `TEC_LVL_HIGH ##1 timer_out);

endmodule

// file: dv/tec_pin_model.sv
// board model that drives the two timer input pins
module tec_pin_model #(
  parameter int HOLD = 12
) (
  input  wire logic clk,
  output logic      timer_in_a,
  output logic      timer_in_b
);
  timeunit 1ns;
  timeprecision 100ps;

  // ********************
  // pin driver
  // ********************
  // push-pull drivers on the board, so the pins always carry a real level
  initial begin
    timer_in_a = 1'b0;
    timer_in_b = 1'b0;
  end

  // each level is held well past two count clocks so a capture is taken cleanly
  task automatic drive(input logic a, input logic b);
    @(negedge clk);
    timer_in_a = a;
    timer_in_b = b;
    repeat (HOLD) @(negedge clk);
  endtask
endmodule

// file: dv/test_tec_ctrl.sv
// self-checking bench for the timer output and edge control slice
`include "tec_cfg.svh"

module test_tec_ctrl;
  timeunit 1ns;
  timeprecision 100ps;

  // ********************
  // signals and counters
  // ********************
  logic        clk;
  logic        rst_n;
  logic [15:0] reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [1:0]  run_mode;
  logic        match_a;
  logic        match_b;
  logic        timer_in_a;
  logic        timer_in_b;
  logic        timer_out;
  logic        irq_match_a;
  logic        irq_match_b;
  logic        count_tick;
  logic        counter_clear;
  logic        capture_a;
  logic        capture_b;
  logic        cmp0_capture_sel;
  logic        cmp1_capture_sel;
  logic [15:0] d;
  int          n_errors;
  int          check_count;
  int          n_tick;
  int          n_cap;
  int          n_capb;
  int          n_irq;
  int          n_clr;
  int          cycles;

  tec_pin_model pm (
    .clk        (clk),
    .timer_in_a (timer_in_a),
    .timer_in_b (timer_in_b)
  );

  tec_ctrl #(.PRE_W(8)) DUT (
    .clk              (clk),
    .rst_n            (rst_n),
    .reg_addr         (reg_addr),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_wdata        (reg_wdata),
    .reg_rdata        (reg_rdata),
    .run_mode         (run_mode),
    .match_a          (match_a),
    .match_b          (match_b),
    .timer_in_a       (timer_in_a),
    .timer_in_b       (timer_in_b),
    .timer_out        (timer_out),
    .irq_match_a      (irq_match_a),
    .irq_match_b      (irq_match_b),
    .count_tick       (count_tick),
    .counter_clear    (counter_clear),
    .capture_a        (capture_a),
    .capture_b        (capture_b),
    .cmp0_capture_sel (cmp0_capture_sel),
    .cmp1_capture_sel (cmp1_capture_sel)
  );

  initial clk = 1'b0;
  always #2 clk = ~clk;

  // pulse counters; a hang is cut short well past the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (count_tick === 1'b1) n_tick <= n_tick + 1;
    if (capture_a === 1'b1) n_cap <= n_cap + 1;
    if (capture_b === 1'b1) n_capb <= n_capb + 1;
    if (irq_match_a === 1'b1) n_irq <= n_irq + 1;
    if (counter_clear === 1'b1) n_clr <= n_clr + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      end_of_test();
    end
  end

  // ********************
  // shared tasks
  // ********************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic zc();
    n_tick = 0;
    n_cap = 0;
    n_capb = 0;
    n_irq = 0;
    n_clr = 0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  // read data is registered, so it is taken one cycle after the strobe drops
  task automatic rd(input logic [15:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    d = 16'(reg_rdata);
  endtask

  task automatic run(input logic [1:0] m);
    @(negedge clk);
    run_mode = m;
  endtask

  // one-cycle match strobe; returns on the falling edge half a cycle after the edge that takes it
  task automatic mt(input logic b);
    @(negedge clk);
    match_b = b;
    match_a = ~b;
    @(negedge clk);
    match_a = 1'b0;
    match_b = 1'b0;
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_reset();
    rd(`TEC_ADDR_OUTCTRL);
    chk("outctrl reset", 16'h0000, d);
    wr(16'hFFBA, 8'hFF);
    rd(16'hFFBA);
    chk("unmapped read", 16'h0000, d);
    rd(`TEC_ADDR_PRESCALER);
    chk("prescaler reset", 16'h0000, d);
    $display("reset test done");
  endtask

  task automatic t_first();
    wr(`TEC_ADDR_PRESCALER, 8'h13);
    pm.drive(1'b1, 1'b0);
    zc();
    run(`TEC_RUN_FREE);
    cyc(10);
    chk("first enable tick", 16'h0001, 16'(n_tick));
    run(`TEC_RUN_STOP);
    zc();
    run(`TEC_RUN_FREE);
    cyc(10);
    chk("re-enable tick", 16'h0000, 16'(n_tick));
    $display("first enable test done");
  endtask

  // one fall then one rise on pin a, counted as edge-clocked ticks
  task automatic t_edges();
    logic [1:0] code [4];
    int         ex [4];
    code = '{2'h0, 2'h1, 2'h3, 2'h2};
    ex = '{1, 1, 2, 0};
    for (int i = 0; i < 4; i++) begin
      run(`TEC_RUN_STOP);
      wr(`TEC_ADDR_PRESCALER, {2'h0, code[i], 4'h3});
      run(`TEC_RUN_FREE);
      zc();
      pm.drive(1'b0, 1'b0);
      pm.drive(1'b1, 1'b0);
      chk("edge ticks", 16'(ex[i]), 16'(n_tick));
    end
    $display("edge select test done");
  endtask

  // a shortfall of up to two ticks below the expected count is tolerated
  task automatic t_clksel();
    int sh [3];
    int e;
    sh = '{0, 2, 8};
    for (int i = 0; i < 3; i++) begin
      run(`TEC_RUN_STOP);
      wr(`TEC_ADDR_PRESCALER, 8'(i));
      run(`TEC_RUN_FREE);
      zc();
      cyc(1024);
      e = 1024 >> sh[i];
      chk("tick rate", 16'(e), 16'((n_tick <= e && n_tick + 2 >= e) ? e : n_tick));
    end
    run(`TEC_RUN_STOP);
    zc();
    cyc(50);
    chk("stopped ticks", 16'h0000, 16'(n_tick));
    $display("clock select test done");
  endtask

  task automatic t_level();
    wr(`TEC_ADDR_OUTCTRL, 8'h22);
    wr(`TEC_ADDR_OUTCTRL, 8'h23);
    wr(`TEC_ADDR_OUTCTRL, 8'h2B);
    cyc(2);
    chk("level set", 16'h0001, 16'(timer_out));
    rd(`TEC_ADDR_OUTCTRL);
    chk("trigger bits read", 16'h0023, d);
    wr(`TEC_ADDR_OUTCTRL, 8'h23);
    cyc(2);
    chk("trigger cleared", 16'h0001, 16'(timer_out));
    wr(`TEC_ADDR_OUTCTRL, 8'h27);
    cyc(2);
    chk("level clear", 16'h0000, 16'(timer_out));
    wr(`TEC_ADDR_OUTCTRL, 8'h2B);
    wr(`TEC_ADDR_OUTCTRL, 8'h22);
    cyc(2);
    chk("output disabled", 16'h0000, 16'(timer_out));
    wr(`TEC_ADDR_OUTCTRL, 8'h2A);
    cyc(2);
    chk("set while disabled", 16'h0000, 16'(timer_out));
    $display("level test done");
  endtask

  task automatic t_match();
    wr(`TEC_ADDR_OUTCTRL, 8'h23);
    run(`TEC_RUN_FREE);
    mt(1'b1);
    chk("irq b", 16'h0001, 16'(irq_match_b));
    chk("toggle on b", 16'h0001, 16'(timer_out));
    cyc(1);
    chk("irq b width", 16'h0000, 16'(irq_match_b));
    mt(1'b0);
    chk("irq a", 16'h0001, 16'(irq_match_a));
    chk("toggle on a", 16'h0000, 16'(timer_out));
    wr(`TEC_ADDR_OUTCTRL, 8'h03);
    mt(1'b1);
    chk("irq b no invert", 16'h0001, 16'(irq_match_b));
    chk("no toggle on b", 16'h0000, 16'(timer_out));
    run(`TEC_RUN_STOP);
    $display("match test done");
  endtask

  task automatic t_capture();
    wr(`TEC_ADDR_CAPCMP, 8'h01);
    wr(`TEC_ADDR_PRESCALER, 8'h40);
    run(`TEC_RUN_FREE);
    cyc(2);
    chk("capture select", 16'h0001, 16'(cmp0_capture_sel));
    zc();
    pm.drive(1'b1, 1'b1);
    pm.drive(1'b1, 1'b0);
    chk("capture on b", 16'h0001, 16'(n_cap));
    run(`TEC_RUN_STOP);
    wr(`TEC_ADDR_CAPCMP, 8'h00);
    run(`TEC_RUN_FREE);
    zc();
    pm.drive(1'b1, 1'b1);
    chk("compare mode capture", 16'h0000, 16'(n_cap));
    chk("edge interrupt", 16'h0001, 16'(n_irq));
    run(`TEC_RUN_STOP);
    wr(`TEC_ADDR_CAPCMP, 8'h03);
    wr(`TEC_ADDR_PRESCALER, 8'h30);
    run(`TEC_RUN_FREE);
    zc();
    pm.drive(1'b0, 1'b1);
    pm.drive(1'b1, 1'b1);
    chk("reverse both edges", 16'h0000, 16'(n_cap));
    run(`TEC_RUN_STOP);
    wr(`TEC_ADDR_CAPCMP, 8'h00);
    $display("capture test done");
  endtask

  task automatic t_oneshot();
    wr(`TEC_ADDR_OUTCTRL, 8'h40);
    wr(`TEC_ADDR_OUTCTRL, 8'h41);
    run(`TEC_RUN_FREE);
    zc();
    wr(`TEC_ADDR_OUTCTRL, 8'h51);
    cyc(2);
    chk("counter clear", 16'h0001, 16'(n_clr));
    rd(`TEC_ADDR_OUTCTRL);
    chk("trigger reads zero", 16'h0041, d);
    mt(1'b1);
    chk("pulse start", 16'h0001, 16'(timer_out));
    mt(1'b0);
    chk("pulse end", 16'h0000, 16'(timer_out));
    run(`TEC_RUN_STOP);
    run(`TEC_RUN_CLR_MATCH);
    wr(`TEC_ADDR_OUTCTRL, 8'h51);
    mt(1'b1);
    chk("no pulse in match clear", 16'h0000, 16'(timer_out));
    run(`TEC_RUN_STOP);
    $display("one-shot test done");
  endtask

  // second register captures on timer_in_a, whose edge also arms the one-shot in edge-clear mode
  task automatic t_edge_clear();
    wr(`TEC_ADDR_CAPCMP, 8'h04);
    wr(`TEC_ADDR_PRESCALER, 8'h10);
    run(`TEC_RUN_CLR_EDGE);
    cyc(2);
    chk("capture select b", 16'h0001, 16'(cmp1_capture_sel));
    zc();
    pm.drive(1'b0, 1'b1);
    pm.drive(1'b1, 1'b1);
    chk("capture on a", 16'h0001, 16'(n_capb));
    mt(1'b1);
    chk("edge-armed pulse", 16'h0001, 16'(timer_out));
    mt(1'b0);
    chk("edge-armed end", 16'h0000, 16'(timer_out));
    run(`TEC_RUN_STOP);
    wr(`TEC_ADDR_CAPCMP, 8'h00);
    $display("edge clear test done");
  endtask

  // ********************
  // main sequence
  // ********************
  initial begin
    rst_n = 1'b0;
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    run_mode = 2'h0;
    match_a = 1'b0;
    match_b = 1'b0;
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    zc();
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_first();
    t_edges();
    t_clksel();
    t_level();
    t_match();
    t_capture();
    t_oneshot();
    t_edge_clear();
    end_of_test();
  end
endmodule
